/* File: logic/asq_consts.svh */
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ----------------------------------------------------------------
// Timing, limits and scale factors
// ----------------------------------------------------------------
`define ASQ_CLK_NS     40
`define ASQ_TICK_NS    100000
`define ASQ_TICK_CYC   ((`ASQ_TICK_NS + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)
`define ASQ_DUR_MIN    29'h0000001
`define ASQ_DUR_MAX    29'h15752A00
`define ASQ_FREQ_MAX   14'h2710
`define ASQ_PHASE_MAX  9'h167
`define ASQ_CYC_MAX    10'h3E7
`define ASQ_NPTS       7'h63
`define ASQ_NCRANK     7'h05
`define ASQ_DFS_X10    37'h000000005D
`define ASQ_DFS_SCALE  37'h00000186A0
`define ASQ_DA_SCALE   46'h00000002710
`define ASQ_PH_PER_HZ  32'h000000AC
`define ASQ_PH_PER_DEG 32'h00B60B61

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASQ_A_CTRL    8'h00
`define ASQ_A_STATUS  8'h04
`define ASQ_A_NOM     8'h08
`define ASQ_A_VSTART  8'h0C
`define ASQ_A_SRCLIM  8'h10
`define ASQ_A_SNKLIM  8'h14
`define ASQ_A_CYCLES  8'h18
`define ASQ_A_PAUSE   8'h1C
`define ASQ_A_BLOCK   8'h20
`define ASQ_A_TRLVL   8'h24
`define ASQ_A_TRT0    8'h28
`define ASQ_A_TRT1    8'h2C
`define ASQ_A_TRT2    8'h30
`define ASQ_A_TRT3    8'h34
`define ASQ_A_PTAMP   8'h38
`define ASQ_A_PTFREQ  8'h3C
`define ASQ_A_PTOFFS  8'h40
`define ASQ_A_PTPHASE 8'h44
`define ASQ_A_PTTIME  8'h48
`define ASQ_A_COMMIT  8'h4C
`define ASQ_A_SETVAL  8'h50

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASQ_RST_NOM   16'h7FFF
`define ASQ_RST_T     29'h00003E8
`define ASQ_CRANK_V   16'h3000

`endif

/* File: logic/asq_pkg.sv */
`default_nettype none

package asq_pkg;
	typedef enum logic [2:0] {
		ASQ_IDLE  = 3'h1,
		ASQ_RUN   = 3'h2,
		ASQ_PAUSE = 3'h4
	} asq_state_t;

	typedef enum logic [1:0] {
		ASQ_TRAP  = 2'h0,
		ASQ_CRANK = 2'h1,
		ASQ_ARB   = 2'h2
	} asq_fn_t;

	typedef struct packed {
		logic signed [15:0] ab;
		logic signed [15:0] af;
		logic [13:0]        fb;
		logic [13:0]        ff;
		logic signed [15:0] ob;
		logic signed [15:0] of;
		logic [8:0]         ph;
		logic [28:0]        t;
	} asq_point_t;

	typedef struct packed {
		asq_state_t         st;
		logic               run;
		logic [1:0]         fn;
		logic               tgt;
		logic               err;
		logic               snk;
		logic               src;
		logic               ld;
		logic [11:0]        tick;
		logic [28:0]        el;
		logic [6:0]         seg;
		logic [9:0]         cyc;
		logic [31:0]        phase;
		logic [15:0]        setv;
		logic [31:0]        prdata;
		logic [15:0]        nomv;
		logic [15:0]        nomi;
		logic [15:0]        vstart;
		logic [15:0]        src_i;
		logic [15:0]        src_p;
		logic [15:0]        snk_i;
		logic [15:0]        snk_p;
		logic [9:0]         cycles;
		logic [28:0]        pause;
		logic [6:0]         blk_b;
		logic [6:0]         blk_f;
		logic signed [15:0] tr_amp;
		logic signed [15:0] tr_off;
		logic [3:0][28:0]   tr_t;
		asq_point_t         stg;
		logic [4:0][15:0]   cr_b;
		logic [4:0][15:0]   cr_f;
		logic [4:0][28:0]   cr_t;
	} asq_regs_t;
endpackage

`default_nettype wire

/* File: logic/asq_top.sv */
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.svh"

module asq_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [15:0] set_value,
	output logic             set_current_sel,
	output logic             sink_only,
	output logic             source_only,
	output logic             run_active
);
	asq_pkg::asq_regs_t  r;
	asq_pkg::asq_regs_t  n;
	asq_pkg::asq_point_t mem [0:98];
	asq_pkg::asq_point_t pt;
	logic                pt_we;
	logic [6:0]          pt_wi;
	logic signed [16:0]  sb, sf, ab, af, fb, ff, dc, am, fq;
	logic [28:0]         dur;
	logic signed [16:0]  ac;
	logic signed [17:0]  sum, lo, hi;
	logic [29:0]         sq;
	logic signed [16:0]  sgn;
	logic                tick_en, seg_end, last, pt_ok, cr_ok, mapped;
	logic [6:0]          first;
	logic [31:0]         rdata;
	logic                wr;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic signed [16:0] lerp(
		input logic signed [16:0] b,
		input logic signed [16:0] f,
		input logic [28:0]        e,
		input logic [28:0]        d);
		logic signed [47:0] p;
		p = 48'(f - b) * $signed({19'h00000, e});
		if (d == 29'h0000000)
			lerp = b;
		else
			lerp = b + 17'(p / $signed({19'h00000, d}));
	endfunction

	function automatic logic [16:0] mag(input logic [15:0] a);
		mag = a[15] ? 17'(-{a[15], a}) : {1'b0, a};
	endfunction

	// Sign and window check of one amplitude/offset pair
	function automatic logic lvl_ok(
		input logic [15:0] a,
		input logic [15:0] o,
		input logic        cur,
		input logic [16:0] nom);
		logic [16:0] aa, oo;
		aa = mag(a);
		oo = mag(o);
		lvl_ok = (cur || (!a[15] && !o[15])) && (aa <= (nom >> 1))
			&& (oo >= aa) && (oo <= nom - aa);
	endfunction

	// ----------------------------------------------------------------
	// Staged point validation
	// ----------------------------------------------------------------
	always_comb begin
		logic [13:0] df;
		logic [16:0] da;
		logic [16:0] nom;
		logic        t_ok;
		df = (r.stg.ff > r.stg.fb) ? r.stg.ff - r.stg.fb
			: r.stg.fb - r.stg.ff;
		da = mag(16'(r.stg.af - r.stg.ab));
		nom = r.tgt ? {1'b0, r.nomi} : {1'b0, r.nomv};
		t_ok = (r.stg.t >= `ASQ_DUR_MIN) && (r.stg.t <= `ASQ_DUR_MAX);
		pt_ok = t_ok
			&& lvl_ok(r.stg.ab, r.stg.ob, r.tgt, nom)
			&& lvl_ok(r.stg.af, r.stg.of, r.tgt, nom)
			&& (r.stg.fb <= `ASQ_FREQ_MAX) && (r.stg.ff <= `ASQ_FREQ_MAX)
			&& (r.stg.ph <= `ASQ_PHASE_MAX)
			&& (df == 14'h0000 || 37'(df) * `ASQ_DFS_SCALE
				>= 37'(r.stg.t) * `ASQ_DFS_X10)
			&& (da == 17'h00000 || 46'(da) * `ASQ_DA_SCALE
				>= 46'(r.stg.t));
		// Cranking points span 0..nominal voltage only
		cr_ok = t_ok && !r.stg.ob[15] && !r.stg.of[15]
			&& (r.stg.ob <= $signed({1'b0, r.nomv[14:0]}))
			&& (r.stg.of <= $signed({1'b0, r.nomv[14:0]}));
	end

	// ----------------------------------------------------------------
	// Point memory
	// ----------------------------------------------------------------
	// No reset: contents only matter once software committed them
	always_ff @(posedge pclk) begin
		if (pt_we)
			mem[pt_wi] <= r.stg;
	end

	// ----------------------------------------------------------------
	// Current segment parameters
	// ----------------------------------------------------------------
	always_comb begin
		logic signed [16:0] top;
		pt = mem[(r.seg >= 7'h01 && r.seg <= `ASQ_NPTS) ?
			7'(r.seg - 7'h01) : 7'h00];
		top = 17'(r.tr_off) + 17'(r.tr_amp);
		sb = 17'(r.tr_off);
		sf = 17'(r.tr_off);
		ab = 17'h00000;
		af = 17'h00000;
		fb = 17'h00000;
		ff = 17'h00000;
		dur = r.tr_t[r.seg[1:0]];
		first = 7'h00;
		last = 1'b0;
		case (r.fn)
			asq_pkg::ASQ_TRAP: begin
				case (r.seg[1:0])
					2'h0: sf = top;
					2'h1: begin
						sb = top;
						sf = top;
					end
					2'h2: sb = top;
					default: last = 1'b1;
				endcase
			end
			asq_pkg::ASQ_CRANK: begin
				if (r.seg < `ASQ_NCRANK) begin
					sb = 17'(r.cr_b[r.seg[2:0]]);
					sf = 17'(r.cr_f[r.seg[2:0]]);
					dur = r.cr_t[r.seg[2:0]];
				end
				last = (r.seg == 7'(`ASQ_NCRANK - 7'h01));
			end
			default: begin
				sb = 17'(pt.ob);
				sf = 17'(pt.of);
				ab = 17'(pt.ab);
				af = 17'(pt.af);
				fb = {3'h0, pt.fb};
				ff = {3'h0, pt.ff};
				dur = pt.t;
				first = r.blk_b;
				last = (r.seg == r.blk_f);
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Waveform arithmetic
	// ----------------------------------------------------------------
	// Parabolic half-wave instead of a sine table: about 5% error,
	// but no ROM and one multiplier
	always_comb begin
		dc = lerp(sb, sf, r.el, dur);
		am = lerp(ab, af, r.el, dur);
		fq = lerp(fb, ff, r.el, dur);
		sq = 30'(r.phase[30:16]) * 30'(16'h8000 - {1'b0, r.phase[30:16]});
		// Peak product is 2^28, so bit 28 must be kept
		sgn = r.phase[31] ? -$signed({2'h0, sq[28:14]})
			: $signed({2'h0, sq[28:14]});
		ac = 17'((34'(am) * 34'(sgn)) >>> 14);
		if (r.fn != asq_pkg::ASQ_ARB || (fb == 17'h00000 && ff == 17'h00000))
			ac = 17'h00000;
		sum = 18'(dc) + 18'(ac);
		lo = r.tgt && r.fn != asq_pkg::ASQ_CRANK ?
			-$signed({2'h0, r.nomi}) : 18'h00000;
		hi = r.tgt && r.fn != asq_pkg::ASQ_CRANK ?
			$signed({2'h0, r.nomi}) : $signed({2'h0, r.nomv});
		if (sum < lo)
			sum = lo;
		else if (sum > hi)
			sum = hi;
	end

	assign tick_en = (r.tick == 12'(`ASQ_TICK_CYC - 1));
	assign seg_end = tick_en && (r.el + 29'h0000001 == dur);
	assign wr = psel && penable && pwrite;

	// ----------------------------------------------------------------
	// Register read mux and decode
	// ----------------------------------------------------------------
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`ASQ_A_CTRL:    rdata = {28'h0000000, r.tgt, r.fn, r.run};
			`ASQ_A_STATUS:  rdata = {6'h00, r.cyc, 1'b0, r.seg, 5'h00, r.err,
				r.st == asq_pkg::ASQ_PAUSE, r.st != asq_pkg::ASQ_IDLE};
			`ASQ_A_NOM:     rdata = {r.nomi, r.nomv};
			`ASQ_A_VSTART:  rdata = {16'h0000, r.vstart};
			`ASQ_A_SRCLIM:  rdata = {r.src_p, r.src_i};
			`ASQ_A_SNKLIM:  rdata = {r.snk_p, r.snk_i};
			`ASQ_A_CYCLES:  rdata = {22'h000000, r.cycles};
			`ASQ_A_PAUSE:   rdata = {3'h0, r.pause};
			`ASQ_A_BLOCK:   rdata = {17'h00000, r.blk_f, 1'b0, r.blk_b};
			`ASQ_A_TRLVL:   rdata = {r.tr_amp, r.tr_off};
			`ASQ_A_TRT0:    rdata = {3'h0, r.tr_t[0]};
			`ASQ_A_TRT1:    rdata = {3'h0, r.tr_t[1]};
			`ASQ_A_TRT2:    rdata = {3'h0, r.tr_t[2]};
			`ASQ_A_TRT3:    rdata = {3'h0, r.tr_t[3]};
			`ASQ_A_PTAMP:   rdata = {r.stg.af, r.stg.ab};
			`ASQ_A_PTFREQ:  rdata = {2'h0, r.stg.ff, 2'h0, r.stg.fb};
			`ASQ_A_PTOFFS:  rdata = {r.stg.of, r.stg.ob};
			`ASQ_A_PTPHASE: rdata = {23'h000000, r.stg.ph};
			`ASQ_A_PTTIME:  rdata = {3'h0, r.stg.t};
			`ASQ_A_COMMIT:  rdata = 32'h00000000;
			`ASQ_A_SETVAL:  rdata = {16'h0000, r.setv};
			default: begin
				rdata = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		pt_we = 1'b0;
		pt_wi = 7'h00;
		n.ld = 1'b0;
		// Read data latched in setup so the access phase is zero-wait
		if (psel && !penable && !pwrite)
			n.prdata = rdata;
		// Clear comes first so a same-cycle rejection still sets it
		if (wr && paddr == `ASQ_A_STATUS && pwdata[2])
			n.err = 1'b0;
		case (r.st)
			asq_pkg::ASQ_IDLE: begin
				n.tick = 12'h000;
				n.el = 29'h0000000;
				n.setv = r.fn == asq_pkg::ASQ_CRANK ? r.vstart : 16'h0000;
				if (r.run && r.fn == 2'h3) begin
					n.run = 1'b0;
					n.err = 1'b1;
				end else if (r.run) begin
					n.st = asq_pkg::ASQ_RUN;
					n.seg = first;
					n.cyc = r.cycles;
					n.ld = 1'b1;
				end
			end
			asq_pkg::ASQ_RUN: begin
				n.setv = 16'(sum);
				n.tick = tick_en ? 12'h000 : 12'(r.tick + 12'h001);
				n.phase = r.ld ? 32'(pt.ph) * `ASQ_PH_PER_DEG
					: r.phase + 32'(fq) * `ASQ_PH_PER_HZ;
				if (!r.run)
					n.st = asq_pkg::ASQ_IDLE;
				else if (seg_end) begin
					n.el = 29'h0000000;
					n.ld = 1'b1;
					if (!last)
						n.seg = 7'(r.seg + 7'h01);
					else if (r.fn == asq_pkg::ASQ_TRAP)
						n.seg = 7'h00;
					else if (r.cycles == 10'h000 || r.cyc > 10'h001) begin
						if (r.cycles != 10'h000)
							n.cyc = 10'(r.cyc - 10'h001);
						n.seg = first;
						if (r.fn == asq_pkg::ASQ_CRANK)
							n.st = asq_pkg::ASQ_PAUSE;
					end else begin
						n.st = asq_pkg::ASQ_IDLE;
						n.run = 1'b0;
					end
				end else if (tick_en)
					n.el = 29'(r.el + 29'h0000001);
			end
			asq_pkg::ASQ_PAUSE: begin
				n.tick = tick_en ? 12'h000 : 12'(r.tick + 12'h001);
				if (!r.run)
					n.st = asq_pkg::ASQ_IDLE;
				else if (tick_en && r.el + 29'h0000001 >= r.pause) begin
					n.el = 29'h0000000;
					n.ld = 1'b1;
					n.st = asq_pkg::ASQ_RUN;
				end else if (tick_en)
					n.el = 29'(r.el + 29'h0000001);
			end
			default: n.st = asq_pkg::ASQ_IDLE;
		endcase
		n.snk = (n.st != asq_pkg::ASQ_IDLE)
			&& (r.src_i == 16'h0000 || r.src_p == 16'h0000);
		n.src = (n.st != asq_pkg::ASQ_IDLE)
			&& (r.snk_i == 16'h0000 || r.snk_p == 16'h0000);
		// Software writes last: a set of run beats the end-of-run clear
		if (wr) begin
			case (paddr)
				`ASQ_A_CTRL: begin
					n.run = pwdata[0];
					if (r.st == asq_pkg::ASQ_IDLE) begin
						n.fn = pwdata[2:1];
						n.tgt = pwdata[3];
					end
				end
				`ASQ_A_NOM: begin
					n.nomv = pwdata[15:0];
					n.nomi = pwdata[31:16];
				end
				`ASQ_A_VSTART: n.vstart = pwdata[15:0];
				`ASQ_A_SRCLIM: begin
					n.src_i = pwdata[15:0];
					n.src_p = pwdata[31:16];
				end
				`ASQ_A_SNKLIM: begin
					n.snk_i = pwdata[15:0];
					n.snk_p = pwdata[31:16];
				end
				`ASQ_A_CYCLES: begin
					if (pwdata[31:0] <= 32'(`ASQ_CYC_MAX))
						n.cycles = pwdata[9:0];
					else
						n.err = 1'b1;
				end
				`ASQ_A_PAUSE: n.pause = pwdata[28:0];
				`ASQ_A_BLOCK: begin
					// Refused while running: live segment must stay inside
					if (n.st == asq_pkg::ASQ_IDLE && pwdata[6:0] >= 7'h01
						&& pwdata[6:0] <= pwdata[14:8]
						&& pwdata[14:8] <= `ASQ_NPTS) begin
						n.blk_b = pwdata[6:0];
						n.blk_f = pwdata[14:8];
					end else
						n.err = 1'b1;
				end
				`ASQ_A_TRLVL: begin
					n.tr_off = pwdata[15:0];
					n.tr_amp = pwdata[31:16];
				end
				`ASQ_A_TRT0, `ASQ_A_TRT1, `ASQ_A_TRT2, `ASQ_A_TRT3: begin
					if (pwdata[28:0] >= `ASQ_DUR_MIN && pwdata[31:29] == 3'h0
						&& pwdata[28:0] <= `ASQ_DUR_MAX)
						n.tr_t[2'(paddr[3:2] + 2'h2)] = pwdata[28:0];
					else
						n.err = 1'b1;
				end
				`ASQ_A_PTAMP: begin
					n.stg.ab = pwdata[15:0];
					n.stg.af = pwdata[31:16];
				end
				`ASQ_A_PTFREQ: begin
					n.stg.fb = pwdata[13:0];
					n.stg.ff = pwdata[29:16];
				end
				`ASQ_A_PTOFFS: begin
					n.stg.ob = pwdata[15:0];
					n.stg.of = pwdata[31:16];
				end
				`ASQ_A_PTPHASE: n.stg.ph = pwdata[8:0];
				`ASQ_A_PTTIME:  n.stg.t = pwdata[28:0];
				`ASQ_A_COMMIT: begin
					if (pwdata[8] && pwdata[6:0] < `ASQ_NCRANK && cr_ok) begin
						n.cr_b[pwdata[2:0]] = r.stg.ob;
						n.cr_f[pwdata[2:0]] = r.stg.of;
						n.cr_t[pwdata[2:0]] = r.stg.t;
					end else if (!pwdata[8] && pwdata[6:0] >= 7'h01
						&& pwdata[6:0] <= `ASQ_NPTS && pt_ok) begin
						pt_we = 1'b1;
						pt_wi = 7'(pwdata[6:0] - 7'h01);
					end else
						n.err = 1'b1;
				end
				default: ; // Read-only and unmapped words ignore writes
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.st <= asq_pkg::ASQ_IDLE;
			r.nomv <= `ASQ_RST_NOM;
			r.nomi <= `ASQ_RST_NOM;
			r.cycles <= 10'h001;
			r.blk_b <= 7'h01;
			r.blk_f <= 7'h01;
			r.tr_t <= {4{`ASQ_RST_T}};
			r.cr_b <= {5{`ASQ_CRANK_V}};
			r.cr_f <= {5{`ASQ_CRANK_V}};
			r.cr_t <= {5{`ASQ_RST_T}};
		end else
			r <= n;
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign set_value = r.setv;
	assign set_current_sel = r.tgt && r.fn != asq_pkg::ASQ_CRANK;
	assign sink_only = r.snk;
	assign source_only = r.src;
	assign run_active = r.st != asq_pkg::ASQ_IDLE;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_seg_done;
		r.st == asq_pkg::ASQ_RUN && r.run && seg_end;
	endsequence

	property p_seg_adv;
		s_seg_done ##0 !last |=> r.el == 29'h0000000
			&& r.seg == 7'($past(r.seg) + 7'h01);
	endproperty
	a_seg_adv: assert property (p_seg_adv) else $error("segment gap");

	property p_restart;
		s_seg_done ##0 (last && r.fn == asq_pkg::ASQ_ARB && r.cyc != 10'h001)
			|=> r.seg == r.blk_b ##1 r.phase == 32'(pt.ph) * `ASQ_PH_PER_DEG;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");

	property p_pause;
		s_seg_done ##0 (last && r.fn == asq_pkg::ASQ_CRANK
			&& r.cyc != 10'h001) |=> r.st == asq_pkg::ASQ_PAUSE;
	endproperty
	a_pause: assert property (p_pause) else $error("pause skipped");

	property p_count_end;
		s_seg_done ##0 (last && r.fn != asq_pkg::ASQ_TRAP
			&& r.cycles != 10'h000 && r.cyc == 10'h001)
			|=> r.st == asq_pkg::ASQ_IDLE && !run_active;
	endproperty
	a_count_end: assert property (p_count_end) else $error("overrun");

	property p_vstart;
		r.st == asq_pkg::ASQ_IDLE && r.fn == asq_pkg::ASQ_CRANK
			|=> set_value == $past(r.vstart);
	endproperty
	a_vstart: assert property (p_vstart) else $error("start level");

	property p_sink;
		run_active && $stable(r.src_i) && $stable(r.src_p)
			|-> sink_only == (r.src_i == 16'h0000 || r.src_p == 16'h0000);
	endproperty
	a_sink: assert property (p_sink) else $error("sink only");

	property p_src_only;
		run_active && $stable(r.snk_i) && $stable(r.snk_p)
			|-> source_only == (r.snk_i == 16'h0000 || r.snk_p == 16'h0000);
	endproperty
	a_src_only: assert property (p_src_only) else $error("source only");

	property p_source;
		!run_active |-> !source_only && !sink_only;
	endproperty
	a_source: assert property (p_source) else $error("mode idle");

	property p_tgt_lock;
		run_active && $past(run_active) |-> $stable(r.tgt);
	endproperty
	a_tgt_lock: assert property (p_tgt_lock) else $error("target");

	property p_block;
		run_active && r.fn == asq_pkg::ASQ_ARB
			|-> r.seg >= r.blk_b && r.seg <= r.blk_f;
	endproperty
	a_block: assert property (p_block) else $error("block range");

	property p_crank_v;
		run_active && r.fn == asq_pkg::ASQ_CRANK |-> !set_current_sel;
	endproperty
	a_crank_v: assert property (p_crank_v) else $error("crank on I");
endmodule

`default_nettype wire

/* File: test/asq_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.svh"

module asq_bench;
	// ------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [15:0] set_value;
	wire         set_current_sel;
	wire         sink_only;
	wire         source_only;
	wire         run_active;
	int          mismatches;
	int          samples_checked;
	int          cyc;
	int          base;
	int          k;
	int          c;
	logic [31:0] seed;
	logic [31:0] r;
	logic [31:0] vs;
	logic [31:0] o;
	logic [31:0] a;
	logic [15:0] cv [5];
	logic        e;

	asq_top dut (
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.set_value       (set_value),
		.set_current_sel (set_current_sel),
		.sink_only       (sink_only),
		.source_only     (source_only),
		.run_active      (run_active)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Xorshift keeps the random draws repeatable
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Only top and base segments have exact levels
	function automatic logic [31:0] trap_exp(input int s, input logic [31:0] ofs,
		input logic [31:0] amp);
		return (s % 4 == 1) ? ofs + amp : ofs;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready, never assumes latency
	task automatic apb(input logic wr_en, input logic [7:0] ad,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr_en;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) mismatches++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask

	task automatic rdm(input logic [7:0] ad, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(r & m, x);
	endtask

	// Waits to a cycle offset from the last run start
	task automatic wt(input int n);
		while (cyc < base + n) @(negedge pclk);
	endtask

	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Whole run needs about 54k cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		seed = 32'hEACD2464;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdm(`ASQ_A_NOM, 32'hFFFFFFFF, 32'h7FFF7FFF);
		rdm(`ASQ_A_CYCLES, 32'hFFFFFFFF, 32'h1);
		rdm(`ASQ_A_BLOCK, 32'hFFFFFFFF, 32'h101);
		rdm(`ASQ_A_TRT0, 32'hFFFFFFFF, 32'h3E8);
		apb(1'b0, 8'h80, 32'h0);
		chk({r[30:0], e}, 32'h1);
		// Over-range count is refused and flagged
		wr(`ASQ_A_CYCLES, 32'h3E8);
		rdm(`ASQ_A_CYCLES, 32'hFFFFFFFF, 32'h1);
		rdm(`ASQ_A_STATUS, 32'h4, 32'h4);
		wr(`ASQ_A_STATUS, 32'h4);
		// Point checks: slow sweep, fast sweep, tiny amp change
		wr(`ASQ_A_PTOFFS, 32'h00100010);
		wr(`ASQ_A_PTPHASE, 32'h0);
		for (k = 0; k < 3; k++) begin
			wr(`ASQ_A_PTAMP, (k == 2) ? 32'h10000 : 32'h0);
			wr(`ASQ_A_PTFREQ, (k == 2) ? 32'h0 : 32'h000B0001);
			wr(`ASQ_A_PTTIME, (k == 0) ? 32'hC350 : 32'h2710 * k);
			wr(`ASQ_A_COMMIT, 32'h1);
			rdm(`ASQ_A_STATUS, 32'h4, (k == 1) ? 32'h0 : 32'h4);
			wr(`ASQ_A_STATUS, 32'h4);
		end
		// Illegal function code refuses to start and flags
		wr(`ASQ_A_CTRL, 32'h7);
		rdm(`ASQ_A_STATUS, 32'h5, 32'h4);
		wr(`ASQ_A_STATUS, 32'h4);
		// Cranking curve, two cycles with a pause
		vs = rnd() & 32'h7FFF;
		wr(`ASQ_A_VSTART, vs);
		wr(`ASQ_A_SRCLIM, 32'h00010000);
		wr(`ASQ_A_SNKLIM, 32'hFFFFFFFF);
		wr(`ASQ_A_CYCLES, 32'h2);
		wr(`ASQ_A_PAUSE, 32'h1);
		for (k = 0; k < 5; k++) begin
			cv[k] = 16'(rnd() & 32'h7FFF);
			wr(`ASQ_A_PTOFFS, {cv[k], cv[k]});
			wr(`ASQ_A_PTTIME, 32'h1);
			wr(`ASQ_A_COMMIT, 32'h100 | k);
		end
		wr(`ASQ_A_CTRL, 32'h2);
		wt(cyc - base + 2);
		chk(set_value, vs);
		wr(`ASQ_A_CTRL, 32'h3);
		base = cyc;
		// Slot 5 of the first cycle falls in the pause
		for (c = 0; c < 2; c++) begin
			for (k = 0; k < 6; k++) begin
				wt(1250 + 2500 * (k + 6 * c));
				if (k < 5) begin
					chk(set_value, cv[k]);
					chk({set_current_sel, sink_only}, 32'h1);
				end else if (c == 0)
					chk({run_active, set_value}, {16'h1, cv[4]});
			end
		end
		chk({run_active, sink_only, set_value}, vs);
		// Trapezoid with four one-tick intervals
		o = rnd() & 32'h3FFF;
		a = rnd() & 32'h3FFF;
		wr(`ASQ_A_TRLVL, {a[15:0], o[15:0]});
		for (k = 0; k < 4; k++) wr(`ASQ_A_TRT0 + 8'(4 * k), 32'h1);
		wr(`ASQ_A_CTRL, 32'h1);
		base = cyc;
		for (k = 1; k < 7; k += 2) begin
			wt(1250 + 2500 * k);
			chk(set_value, trap_exp(k, o, a));
		end
		wr(`ASQ_A_CTRL, 32'h0);
		wt(cyc - base + 2);
		chk(run_active, 32'h0);
		// Points 98 (sine, 90 deg start: peak) and 99 (flat DC),
		// current target, block run twice
		wr(`ASQ_A_SRCLIM, 32'hFFFFFFFF);
		wr(`ASQ_A_SNKLIM, 32'h00000001);
		a = rnd() & 32'hFFF;
		vs = (rnd() & 32'h3FFF) + 32'h1000;
		wr(`ASQ_A_PTAMP, {a[15:0], a[15:0]});
		wr(`ASQ_A_PTFREQ, 32'h00010001);
		wr(`ASQ_A_PTOFFS, {vs[15:0], vs[15:0]});
		wr(`ASQ_A_PTPHASE, 32'h5A);
		wr(`ASQ_A_PTTIME, 32'h1);
		wr(`ASQ_A_COMMIT, 32'h62);
		o = rnd() & 32'h7FFF;
		wr(`ASQ_A_PTAMP, 32'h0);
		wr(`ASQ_A_PTFREQ, 32'h0);
		wr(`ASQ_A_PTOFFS, {o[15:0], o[15:0]});
		wr(`ASQ_A_COMMIT, 32'h63);
		wr(`ASQ_A_BLOCK, 32'h6362);
		wr(`ASQ_A_CYCLES, 32'h2);
		wr(`ASQ_A_CTRL, 32'hD);
		base = cyc;
		// 1 Hz keeps the phase near its peak for some 380 cycles
		for (c = 0; c < 2; c++) begin
			wt(100 + 5000 * c);
			chk(set_value, vs + a);
			wt(3750 + 5000 * c);
			chk(set_value, o);
		end
		chk({set_current_sel, source_only, sink_only}, 32'h6);
		wt(11250);
		chk(run_active, 32'h0);
		summarize();
	end
endmodule

`default_nettype wire
